// File: src/slf_map.vh
// Command codes, field positions and reset values of the limit supervisor.
// Included by the supervisor top; holds definitions only.
`ifndef SLF_MAP_VH
`define SLF_MAP_VH
`define SLF_SLAVE_ADDR 7'h20
`define SLF_CMD_CLEAR 8'h03
`define SLF_CMD_FANCFG 8'h3A
`define SLF_CMD_FANOVR 8'h3B
`define SLF_CMD_OVF 8'h40
`define SLF_CMD_OVW 8'h42
`define SLF_CMD_UVW 8'h43
`define SLF_CMD_UVF 8'h44
`define SLF_CMD_OCW 8'h46
`define SLF_CMD_OCF 8'h4A
`define SLF_CMD_OTF 8'h4F
`define SLF_CMD_OTW 8'h51
`define SLF_CMD_STBYTE 8'h78
`define SLF_CMD_STWORD 8'h79
`define SLF_CMD_STVOUT 8'h7A
`define SLF_CMD_STVEND 8'h80
`define SLF_IX_OVF 3'h0
`define SLF_IX_OVW 3'h1
`define SLF_IX_UVW 3'h2
`define SLF_IX_UVF 3'h3
`define SLF_IX_OCW 3'h4
`define SLF_IX_OCF 3'h5
`define SLF_IX_OTF 3'h6
`define SLF_IX_OTW 3'h7
`define SLF_FAN_ON 7
`define SLF_FAN_RPM 6
`define SLF_FAN_PULSE_HI 5
`define SLF_FAN_PULSE_LO 4
`define SLF_SB_OV 5
`define SLF_SB_OC 4
`define SLF_SB_TEMP 2
`define SLF_SB_CML 1
`define SLF_SB_OTHER 0
`define SLF_SW_OUTPUT_VOLTAGE_FLAG 15
`define SLF_SW_OUTPUT_CURRENT_FLAG 14
`define SLF_SW_VEND 12
`define SLF_SV_OVF 7
`define SLF_SV_OVW 6
`define SLF_SV_UVW 5
`define SLF_SV_UVF 4
`define SLF_SV_TON 2
`define SLF_VS_OTW 0
`define SLF_VS_OTF 1
`define SLF_VS_OCW 2
`define SLF_VS_OCF 3
`define SLF_FANCFG_RST 8'h00
`define SLF_FANOVR_RST 16'hFFFF
`define SLF_THR_RST 16'h0000
`define SLF_DUTY_FULL 16'h2710
`endif

// File: src/slf_thr_mem.v
// Threshold store: eight 16-bit words, one write port, two registered read ports.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/100ps
module slf_thr_mem
(
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Write port
   input wire we,
   input wire [2:0] wAddr,
   input wire [15:0] wData,
   // Read ports
   input wire [2:0] rAddrA,
   output reg [15:0] rDataA,
   input wire [2:0] rAddrB,
   output reg [15:0] rDataB
);
`include "slf_map.vh"
   reg [15:0] mem [0:7];
   genvar g;

   generate
      for (g = 0; g < 8; g = g + 1)
      begin : gWord
         always @(posedge clk)
         begin
            if (!nrst)
               mem[g] <= `SLF_THR_RST;
            else if (we && wAddr == g)
               mem[g] <= wData;
         end
      end
   endgenerate

   always @(posedge clk)
   begin
      if (!nrst)
      begin
         rDataA <= 16'h0000;
         rDataB <= 16'h0000;
      end
      else
      begin
         rDataA <= mem[rAddrA];
         rDataB <= mem[rAddrB];
      end
   end
endmodule

// File: src/slf_limit_top.v
// Limit supervisor and fan override, reached over a two-wire management bus.
// Assumes measurements arrive on clk with one-cycle valid strobes; bus pins
// are asynchronous and are sampled by clk, which must run far above the bus.
// Operation
// - Fan-on clear forces fan drive low
// - Select bit picks duty or speed units
// - Pulse field codes one to four pulses
// - Low nibble of fan setup reads zero
// - Negative override falls back to automatic control
// - Duty override saturates at full scale
// - Speed override used directly as RPM
// - Thresholds and override are two-byte words
// - Overvoltage fault sets flags and fault action
// - Overvoltage warning sets other and voltage flags
// - Undervoltage warning masked until armed, turn-off
// - Undervoltage fault masked likewise, acts on fault
// - Undervoltage fault level ends turn-on check
// - Overcurrent warning sets other, current, vendor flags
// - Overcurrent fault sets flags and fault action
// - Zero overcurrent fault threshold disables current
// - Overtemperature fault sets thermal flags, acts
// - Overtemperature warning sets thermal flags only
// - Summary byte bit layout
// - Summary word layout, low byte mirrors
// - Voltage status byte layout
`timescale 1ns/100ps
module slf_limit_top
(
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Management bus pins
   input wire scl,
   input wire sdaIn,
   output wire sdaOut,
   output reg sdaOe,
   // Measurement results
   input wire [15:0] measVolt,
   input wire voltValid,
   input wire [15:0] measCur,
   input wire curValid,
   input wire [15:0] measTemp,
   input wire tempValid,
   // Sequencing and mode settings
   input wire supplyOff,
   input wire tonTimeout,
   input wire alertEn,
   input wire faultRespEn,
   // Fan
   input wire fanPwmIn,
   output reg fanDrivePin,
   output reg fanSpeedMode,
   output reg [2:0] fanTachPulses,
   output reg fanOverride,
   output reg [15:0] fanTarget,
   // Supervision results
   output reg curMeasEn,
   output reg uvCrossed,
   output reg faultAction,
   output reg alertOe
);
`include "slf_map.vh"
   localparam S_IDLE = 3'h0;
   localparam S_ADDR = 3'h1;
   localparam S_RX = 3'h2;
   localparam S_ACK = 3'h3;
   localparam S_TX = 3'h4;
   localparam S_MACK = 3'h5;
   localparam S_TXN = 3'h6;

   // Threshold command to {valid, index}
   function [3:0] thrIx;
      input [7:0] c;
      begin
         case (c)
            `SLF_CMD_OVF: thrIx = {1'b1, `SLF_IX_OVF};
            `SLF_CMD_OVW: thrIx = {1'b1, `SLF_IX_OVW};
            `SLF_CMD_UVW: thrIx = {1'b1, `SLF_IX_UVW};
            `SLF_CMD_UVF: thrIx = {1'b1, `SLF_IX_UVF};
            `SLF_CMD_OCW: thrIx = {1'b1, `SLF_IX_OCW};
            `SLF_CMD_OCF: thrIx = {1'b1, `SLF_IX_OCF};
            `SLF_CMD_OTF: thrIx = {1'b1, `SLF_IX_OTF};
            `SLF_CMD_OTW: thrIx = {1'b1, `SLF_IX_OTW};
            default: thrIx = 4'h0;
         endcase
      end
   endfunction

   // Pin synchronisers; the first stages feed only the second stages
   reg scl1_q, scl2_q, sclP_q, sda1_q, sda2_q, sdaP_q;
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         scl1_q <= 1'b1;
         scl2_q <= 1'b1;
         sclP_q <= 1'b1;
         sda1_q <= 1'b1;
         sda2_q <= 1'b1;
         sdaP_q <= 1'b1;
      end
      else
      begin
         scl1_q <= scl;
         scl2_q <= scl1_q;
         sclP_q <= scl2_q;
         sda1_q <= sdaIn;
         sda2_q <= sda1_q;
         sdaP_q <= sda2_q;
      end
   end
   wire sclRise = scl2_q & ~sclP_q;
   wire sclFall = ~scl2_q & sclP_q;
   wire busStart = scl2_q & sclP_q & sdaP_q & ~sda2_q;
   wire busStop = scl2_q & sclP_q & ~sdaP_q & sda2_q;
   assign sdaOut = 1'b0;

   reg [2:0] st_q;
   reg [3:0] bit_q;
   reg [1:0] byte_q;
   reg [7:0] sh_q, tx_q, cmd_q, wlo_q, clrMask_q, fanCfg_q;
   reg [15:0] fanOvr_q;
   reg rd_q, ack_q, we_q, clrV_q, clrM_q, clrC_q, cmlSet_q;
   reg [2:0] wAddr_q;
   reg [15:0] wData_q;
   reg [7:0] output_voltage_flag_q;
   reg [3:0] vend_q;
   reg cml_q;
   wire [15:0] rDataA, rDataB;
   wire [7:0] rxByte = {sh_q[6:0], sda2_q};
   wire [3:0] cmdIx = thrIx(cmd_q);
   wire [3:0] rxIx = thrIx(rxByte);
   wire [1:0] byteNx = byte_q + {1'b0, (byte_q != 2'h3)};

   // Summary views, built from the detailed flags
   wire other = output_voltage_flag_q[`SLF_SV_OVW] | output_voltage_flag_q[`SLF_SV_UVW] | output_voltage_flag_q[`SLF_SV_UVF]
      | output_voltage_flag_q[`SLF_SV_TON] | vend_q[`SLF_VS_OCW];
   wire therm = vend_q[`SLF_VS_OTF] | vend_q[`SLF_VS_OTW];
   wire [7:0] stByte = {2'b00, output_voltage_flag_q[`SLF_SV_OVF], vend_q[`SLF_VS_OCF], 1'b0,
      therm, cml_q, other};
   wire [15:0] stWord = {(|output_voltage_flag_q), (vend_q[`SLF_VS_OCW] | vend_q[`SLF_VS_OCF]),
      1'b0, (|vend_q), 4'h0, stByte};

   // Read word for the current command, sent low byte first
   reg [15:0] rdWord;
   reg [7:0] rdByte;
   always @*
   begin
      case (cmd_q)
         `SLF_CMD_FANCFG: rdWord = {8'h00, fanCfg_q[7:4], 4'h0};
         `SLF_CMD_FANOVR: rdWord = fanOvr_q;
         `SLF_CMD_STBYTE: rdWord = {8'h00, stByte};
         `SLF_CMD_STWORD: rdWord = stWord;
         `SLF_CMD_STVOUT: rdWord = {8'h00, output_voltage_flag_q};
         `SLF_CMD_STVEND: rdWord = {12'h000, vend_q};
         default: rdWord = cmdIx[3] ? rDataA : 16'h0000;
      endcase
      case (byte_q)
         2'h0: rdByte = rdWord[7:0];
         2'h1: rdByte = rdWord[15:8];
         default: rdByte = 8'h00;
      endcase
   end

   // Bus slave: bytes in on SCL rise, SDA changed only after SCL fall
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         st_q <= S_IDLE;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         cmd_q <= 8'h00;
         wlo_q <= 8'h00;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         sdaOe <= 1'b0;
         we_q <= 1'b0;
         wAddr_q <= 3'h0;
         wData_q <= 16'h0000;
         clrMask_q <= 8'h00;
         clrV_q <= 1'b0;
         clrM_q <= 1'b0;
         clrC_q <= 1'b0;
         cmlSet_q <= 1'b0;
         fanCfg_q <= `SLF_FANCFG_RST;
         fanOvr_q <= `SLF_FANOVR_RST;
      end
      else
      begin
         we_q <= 1'b0;
         clrV_q <= 1'b0;
         clrM_q <= 1'b0;
         clrC_q <= 1'b0;
         cmlSet_q <= 1'b0;
         if (busStart)
         begin
            st_q <= S_ADDR;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            ack_q <= 1'b0;
            sdaOe <= 1'b0;
         end
         else if (busStop)
         begin
            st_q <= S_IDLE;
            sdaOe <= 1'b0;
         end
         else
            case (st_q)
               S_IDLE: st_q <= S_IDLE;
               S_ADDR, S_RX:
                  if (sclRise)
                  begin
                     sh_q <= rxByte;
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h7)
                     begin
                        st_q <= S_ACK;
                        if (st_q == S_ADDR)
                        begin
                           rd_q <= sda2_q;
                           if (sh_q[6:0] != `SLF_SLAVE_ADDR)
                              st_q <= S_IDLE;
                        end
                        else
                        begin
                           byte_q <= byteNx;
                           if (byte_q == 2'h0)
                           begin
                              cmd_q <= rxByte;
                              if (rxByte == `SLF_CMD_CLEAR)
                              begin
                                 clrMask_q <= 8'hFF;
                                 clrV_q <= 1'b1;
                                 clrM_q <= 1'b1;
                                 clrC_q <= 1'b1;
                              end
                              else if (!rxIx[3] && rxByte != `SLF_CMD_FANCFG
                                 && rxByte != `SLF_CMD_FANOVR && rxByte != `SLF_CMD_STBYTE
                                 && rxByte != `SLF_CMD_STWORD && rxByte != `SLF_CMD_STVOUT
                                 && rxByte != `SLF_CMD_STVEND)
                                 cmlSet_q <= 1'b1;
                           end
                           else if (byte_q == 2'h1)
                           begin
                              wlo_q <= rxByte;
                              clrMask_q <= rxByte;
                              if (cmd_q == `SLF_CMD_FANCFG)
                                 fanCfg_q <= {rxByte[7:4], 4'h0};
                              clrV_q <= (cmd_q == `SLF_CMD_STVOUT);
                              clrM_q <= (cmd_q == `SLF_CMD_STVEND);
                              clrC_q <= (cmd_q == `SLF_CMD_STBYTE);
                           end
                           else if (byte_q == 2'h2)
                           begin
                              // Word takes effect only once both bytes are in
                              if (cmd_q == `SLF_CMD_FANOVR)
                                 fanOvr_q <= {rxByte, wlo_q};
                              we_q <= cmdIx[3];
                              wAddr_q <= cmdIx[2:0];
                              wData_q <= {rxByte, wlo_q};
                           end
                        end
                     end
                  end
               S_ACK:
                  if (sclFall)
                  begin
                     if (!ack_q)
                     begin
                        sdaOe <= 1'b1;
                        ack_q <= 1'b1;
                     end
                     else
                     begin
                        ack_q <= 1'b0;
                        bit_q <= 4'h0;
                        if (rd_q)
                        begin
                           tx_q <= rdByte;
                           sdaOe <= ~rdByte[7];
                           bit_q <= 4'h1;
                           st_q <= S_TX;
                        end
                        else
                        begin
                           sdaOe <= 1'b0;
                           st_q <= S_RX;
                        end
                     end
                  end
               S_TX:
                  if (sclFall)
                  begin
                     if (bit_q == 4'h8)
                     begin
                        sdaOe <= 1'b0;
                        byte_q <= byteNx;
                        st_q <= S_MACK;
                     end
                     else
                     begin
                        sdaOe <= ~tx_q[6];
                        tx_q <= {tx_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               S_MACK:
                  if (sclRise)
                     st_q <= sda2_q ? S_IDLE : S_TXN;
               S_TXN:
                  if (sclFall)
                  begin
                     tx_q <= rdByte;
                     sdaOe <= ~rdByte[7];
                     bit_q <= 4'h1;
                     st_q <= S_TX;
                  end
               default: st_q <= S_IDLE;
            endcase
      end
   end

   // Scanner walks the eight thresholds, one compare per cycle
   reg [2:0] scan_q, cmpIx_q;
   reg [2:0] pend_q, act_q;
   reg [15:0] vLat_q, cLat_q, tLat_q, vS_q, cS_q, tS_q;
   reg uvArmed_q;
   wire passStart = (scan_q == 3'h0);

   slf_thr_mem uMem
   (
      .clk(clk),
      .nrst(nrst),
      .we(we_q),
      .wAddr(wAddr_q),
      .wData(wData_q),
      .rAddrA(cmdIx[2:0]),
      .rDataA(rDataA),
      .rAddrB(scan_q),
      .rDataB(rDataB)
   );

   wire signed [15:0] thr = rDataB;
   wire signed [15:0] vS = vS_q;
   wire signed [15:0] cS = cS_q;
   wire signed [15:0] tS = tS_q;
   reg [7:0] svSet;
   reg [3:0] vmSet;
   reg armSet;
   always @*
   begin
      svSet = 8'h00;
      vmSet = 4'h0;
      armSet = 1'b0;
      case (cmpIx_q)
         `SLF_IX_OVF: svSet[`SLF_SV_OVF] = act_q[0] & (vS > thr);
         `SLF_IX_OVW: svSet[`SLF_SV_OVW] = act_q[0] & (vS > thr);
         `SLF_IX_UVW: svSet[`SLF_SV_UVW] = act_q[0] & uvArmed_q & ~supplyOff & (vS < thr);
         `SLF_IX_UVF:
         begin
            svSet[`SLF_SV_UVF] = act_q[0] & uvArmed_q & ~supplyOff & (vS < thr);
            armSet = act_q[0] & ~supplyOff & (vS >= thr);
         end
         `SLF_IX_OCW: vmSet[`SLF_VS_OCW] = act_q[1] & curMeasEn & (cS > thr);
         `SLF_IX_OCF: vmSet[`SLF_VS_OCF] = act_q[1] & curMeasEn & (cS > thr);
         `SLF_IX_OTF: vmSet[`SLF_VS_OTF] = act_q[2] & (tS > thr);
         `SLF_IX_OTW: vmSet[`SLF_VS_OTW] = act_q[2] & (tS > thr);
         default: svSet = 8'h00;
      endcase
      svSet[`SLF_SV_TON] = tonTimeout;
   end

   wire newFault = svSet[`SLF_SV_OVF] | svSet[`SLF_SV_UVF] | svSet[`SLF_SV_TON]
      | vmSet[`SLF_VS_OCF] | vmSet[`SLF_VS_OTF];
   wire anySet = (|svSet) | (|vmSet) | cmlSet_q;

   always @(posedge clk)
   begin
      if (!nrst)
      begin
         scan_q <= 3'h0;
         cmpIx_q <= 3'h0;
         pend_q <= 3'h0;
         act_q <= 3'h0;
         vLat_q <= 16'h0000;
         cLat_q <= 16'h0000;
         tLat_q <= 16'h0000;
         vS_q <= 16'h0000;
         cS_q <= 16'h0000;
         tS_q <= 16'h0000;
         uvArmed_q <= 1'b0;
         curMeasEn <= 1'b0;
         output_voltage_flag_q <= 8'h00;
         vend_q <= 4'h0;
         cml_q <= 1'b0;
         faultAction <= 1'b0;
         alertOe <= 1'b0;
         uvCrossed <= 1'b0;
      end
      else
      begin
         scan_q <= scan_q + 3'h1;
         cmpIx_q <= scan_q;
         // Only results that arrived since the last pass are judged
         pend_q <= (passStart ? 3'h0 : pend_q) | {tempValid, curValid, voltValid};
         if (passStart)
         begin
            act_q <= pend_q;
            vS_q <= vLat_q;
            cS_q <= cLat_q;
            tS_q <= tLat_q;
         end
         if (voltValid)
            vLat_q <= measVolt;
         if (curValid)
            cLat_q <= measCur;
         if (tempValid)
            tLat_q <= measTemp;
         if (cmpIx_q == `SLF_IX_OCF)
            curMeasEn <= (rDataB != 16'h0000) & ~rDataB[15];
         if (supplyOff)
            uvArmed_q <= 1'b0;
         else if (armSet)
            uvArmed_q <= 1'b1;
         uvCrossed <= ~supplyOff & (uvArmed_q | armSet);
         // Set wins over a clear in the same cycle
         output_voltage_flag_q <= (output_voltage_flag_q & ~(clrV_q ? clrMask_q : 8'h00)) | svSet;
         vend_q <= (vend_q & ~(clrM_q ? clrMask_q[3:0] : 4'h0)) | vmSet;
         cml_q <= (cml_q & ~clrC_q) | cmlSet_q;
         // Level while any fault flag stands, so a late enable still acts
         faultAction <= faultRespEn & (newFault | output_voltage_flag_q[`SLF_SV_OVF] | output_voltage_flag_q[`SLF_SV_UVF]
            | output_voltage_flag_q[`SLF_SV_TON] | vend_q[`SLF_VS_OCF] | vend_q[`SLF_VS_OTF]);
         // Held while any flag stays set, dropped when all are cleared
         alertOe <= alertEn & (anySet | (alertOe & ((|output_voltage_flag_q) | (|vend_q) | cml_q)));
      end
   end

   // Fan outputs
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         fanDrivePin <= 1'b0;
         fanSpeedMode <= 1'b0;
         fanTachPulses <= 3'h1;
         fanOverride <= 1'b0;
         fanTarget <= 16'h0000;
      end
      else
      begin
         fanDrivePin <= fanCfg_q[`SLF_FAN_ON] & fanPwmIn;
         fanSpeedMode <= fanCfg_q[`SLF_FAN_RPM];
         fanTachPulses <= {1'b0, fanCfg_q[`SLF_FAN_PULSE_HI:`SLF_FAN_PULSE_LO]} + 3'h1;
         fanOverride <= ~fanOvr_q[15];
         if (fanCfg_q[`SLF_FAN_RPM])
            fanTarget <= fanOvr_q[15] ? 16'h0000 : fanOvr_q;
         else if (fanOvr_q[15])
            fanTarget <= 16'h0000;
         else if (fanOvr_q > `SLF_DUTY_FULL)
            fanTarget <= `SLF_DUTY_FULL;
         else
            fanTarget <= fanOvr_q;
      end
   end
endmodule

// File: sim/slf_host_model.sv
// Bus host model: drives the clock and data pins of the supervisor bus.
// Assumes a pulled-up data wire; moves on falling clk.
`timescale 1ns/100ps
`include "slf_map.vh"
module slf_host_model
(
   // Clock
   input wire clk,
   // Bus pins
   output logic scl,
   output logic sdaM,
   input wire sda
);
   logic [6:0] devAddr = `SLF_SLAVE_ADDR;
   logic addrAck = 1'b0;
   logic [7:0] q;
   logic n;
   initial
   begin
      scl = 1'b1;
      sdaM = 1'b1;
   end
   // Half of an 80 ns bus period
   task automatic hp;
      repeat (4) @(negedge clk);
   endtask
   // Also serves as repeated start
   task automatic start;
      sdaM = 1'b1;
      hp;
      scl = 1'b1;
      hp;
      sdaM = 1'b0;
      hp;
      scl = 1'b0;
   endtask
   task automatic stop;
      sdaM = 1'b0;
      hp;
      scl = 1'b1;
      hp;
      sdaM = 1'b1;
      hp;
   endtask
   // Sampled late in the high phase
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] o,
      output logic k);
      logic [8:0] r;
      r = 9'h000;
      for (int i = 8; i >= 0; i--)
      begin
         sdaM = (i == 0) ? a : d[i - 1];
         hp;
         scl = 1'b1;
         hp;
         r = {r[7:0], sda};
         scl = 1'b0;
      end
      o = r[8:1];
      k = r[0];
   endtask
   task automatic head(input logic [7:0] c);
      start;
      xfer({devAddr, 1'b0}, 1'b1, q, n);
      addrAck = ~n;
      xfer(c, 1'b1, q, n);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int nb);
      head(c);
      if (nb > 0)
         xfer(d[7:0], 1'b1, q, n);
      if (nb > 1)
         xfer(d[15:8], 1'b1, q, n);
      stop;
   endtask
   // The low byte is acknowledged when two are read, the last byte refused
   task automatic rd(input logic [7:0] c, input int nb, output logic [15:0] v);
      v = 16'h0000;
      head(c);
      start;
      xfer({devAddr, 1'b1}, 1'b1, q, n);
      xfer(8'hFF, nb < 2, v[7:0], n);
      if (nb > 1)
         xfer(8'hFF, 1'b1, v[15:8], n);
      stop;
   endtask
endmodule

// File: sim/slf_limit_top_assertions.sv
// Port checker of the limit supervisor top.
// Assumes one clock domain; bound to every instance of the top.
`timescale 1ns/100ps
module slf_limit_top_assertions
(
   input wire clk,
   input wire nrst,
   input wire scl,
   input wire sdaOe,
   input wire supplyOff,
   input wire alertEn,
   input wire faultRespEn,
   input wire fanPwmIn,
   input wire fanDrivePin,
   input wire fanSpeedMode,
   input wire [2:0] fanTachPulses,
   input wire fanOverride,
   input wire [15:0] fanTarget,
   input wire uvCrossed,
   input wire faultAction,
   input wire alertOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence pullHeld;
      sdaOe [*4];
   endsequence
   chk_ack_hold: assert property ($rose(sdaOe) |-> pullHeld)
      else $error("ack short");
   chk_ack_scl_low: assert property ($changed(sdaOe) |-> !$past(scl))
      else $error("pull moved, clock high");
   chk_drive_gate: assert property (fanDrivePin |-> $past(fanPwmIn))
      else $error("drive, no pulse");
   chk_tach_range: assert property (fanTachPulses inside {[1:4]})
      else $error("tach range");
   chk_duty_clamp: assert property (fanOverride && !fanSpeedMode |-> fanTarget <= 16'h2710)
      else $error("duty over full");
   chk_no_override: assert property (!fanOverride |-> fanTarget == 16'h0000)
      else $error("target, no override");
   chk_alert_gate: assert property (!$past(alertEn) |-> !alertOe)
      else $error("alert off");
   chk_action_gate: assert property (!$past(faultRespEn) |-> !faultAction)
      else $error("action off");
   chk_uv_disarm: assert property ($past(supplyOff) |-> !uvCrossed)
      else $error("armed while off");
   chk_alert_fault: assert property ($rose(faultAction) && $past(alertEn) |-> alertOe)
      else $error("no alert");
endmodule
bind slf_limit_top slf_limit_top_assertions slf_limit_top_assertions_inst (.*);

// File: sim/slf_limit_top_bench.sv
// Self-checking bench of the limit supervisor, driven through the bus host model.
// Assumes the host model and the bound port checker are compiled with it.
`timescale 1ns/100ps
`include "slf_map.vh"
module slf_limit_top_bench;
   logic clk, nrst, scl, sdaM, sdaOut, sdaOe, fanPwmIn, fanDrivePin, fanSpeedMode;
   logic voltValid, curValid, tempValid, supplyOff, tonTimeout, alertEn, faultRespEn;
   logic fanOverride, curMeasEn, uvCrossed, faultAction, alertOe;
   logic [15:0] measVolt, measCur, measTemp, fanTarget;
   logic [2:0] fanTachPulses;
   int nErrors = 0;
   int checkCount = 0;
   // Mode, override, expected flag and target
   logic [40:0] ovrTab [0:6] = '{{8'h80, 16'h2710, 1'b1, 16'h2710},
      {8'h80, 16'h2711, 1'b1, 16'h2710}, {8'h80, 16'h7FFF, 1'b1, 16'h2710},
      {8'h80, 16'h8000, 1'b0, 16'h0000}, {8'hC0, 16'h7FFF, 1'b1, 16'h7FFF},
      {8'hC0, 16'hFFFF, 1'b0, 16'h0000}, {8'hC0, 16'h0000, 1'b1, 16'h0000}};
   logic [7:0] thrCmd [0:7] = '{`SLF_CMD_OVF, `SLF_CMD_OVW, `SLF_CMD_UVW, `SLF_CMD_UVF,
      `SLF_CMD_OCW, `SLF_CMD_OCF, `SLF_CMD_OTF, `SLF_CMD_OTW};
   logic [15:0] thrVal [0:7] = '{16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0080,
      16'h0000, 16'h0050, 16'h0040};
   // Pull-up: a released wire reads high
   wire sda = sdaM & ~sdaOe;
   slf_limit_top slf_limit_top_inst (.sdaIn(sda), .*);
   slf_host_model slf_host_model_inst (.*);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [15:0] f2(input logic a, input logic b);
      return {14'h0000, a, b};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp)
      begin
         nErrors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic testDone;
      $display("checks %0d mismatches %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int nb);
      slf_host_model_inst.wr(c, d, nb);
   endtask
   task automatic rdc(input logic [7:0] c, input int nb, input logic [15:0] e);
      logic [15:0] v;
      slf_host_model_inst.rd(c, nb, v);
      chk(v, e);
   endtask
   // Results are judged by a scan pass within 18 cycles
   task automatic meas(input int ch, input logic [15:0] v);
      @(negedge clk);
      {measVolt, measCur, measTemp} = {3{v}};
      {tempValid, curValid, voltValid} = 3'b001 << ch;
      @(negedge clk);
      {tempValid, curValid, voltValid} = 3'b000;
      repeat (20) @(negedge clk);
   endtask
   task automatic stat(input logic [15:0] w, input logic [7:0] vo, input logic [7:0] vs);
      rdc(`SLF_CMD_STWORD, 2, w);
      rdc(`SLF_CMD_STBYTE, 1, {8'h00, w[7:0]});
      rdc(`SLF_CMD_STVOUT, 1, {8'h00, vo});
      rdc(`SLF_CMD_STVEND, 1, {8'h00, vs});
   endtask
   initial
   begin
      nrst = 1'b0;
      {measVolt, measCur, measTemp} = {3{16'h0000}};
      {voltValid, curValid, tempValid, supplyOff, tonTimeout} = 5'h00;
      {alertEn, faultRespEn, fanPwmIn} = 3'h7;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      rdc(`SLF_CMD_FANCFG, 1, 16'h0000);
      rdc(`SLF_CMD_FANOVR, 2, 16'hFFFF);
      chk({11'h000, curMeasEn, fanOverride, fanTachPulses}, 16'h0001);
      $display("reset test done");
      for (int k = 0; k < 4; k++)
      begin
         wr(`SLF_CMD_FANCFG, {10'h001, k[1:0], 4'hF}, 1);
         rdc(`SLF_CMD_FANCFG, 1, {10'h001, k[1:0], 4'h0});
         chk({12'h000, fanSpeedMode, fanTachPulses}, 16'(k + 9));
      end
      chk(f2(1'b0, fanDrivePin), 16'h0000);
      wr(`SLF_CMD_FANCFG, 16'h0080, 1);
      chk(f2(1'b0, fanDrivePin), 16'h0001);
      foreach (ovrTab[i])
      begin
         wr(`SLF_CMD_FANCFG, {8'h00, ovrTab[i][40:33]}, 1);
         wr(`SLF_CMD_FANOVR, ovrTab[i][32:17], 2);
         rdc(`SLF_CMD_FANOVR, 2, ovrTab[i][32:17]);
         chk(f2(1'b0, fanOverride), f2(1'b0, ovrTab[i][16]));
         chk(fanTarget, ovrTab[i][15:0]);
      end
      wr(`SLF_CMD_FANOVR, 16'h0055, 1);
      rdc(`SLF_CMD_FANOVR, 2, 16'h0000);
      $display("fan test done");
      foreach (thrCmd[i])
         wr(thrCmd[i], thrVal[i], 2);
      foreach (thrCmd[i])
         rdc(thrCmd[i], 2, thrVal[i]);
      meas(1, 16'h7000);
      stat(16'h0000, 8'h00, 8'h00);
      wr(`SLF_CMD_OCF, 16'h0100, 2);
      chk(f2(1'b0, curMeasEn), 16'h0001);
      meas(1, 16'h00C0);
      stat(16'h5001, 8'h00, 8'h04);
      chk(f2(alertOe, faultAction), 16'h0002);
      meas(1, 16'h0200);
      stat(16'h5011, 8'h00, 8'h0C);
      chk(f2(alertOe, faultAction), 16'h0003);
      wr(`SLF_CMD_CLEAR, 16'h0000, 0);
      stat(16'h0000, 8'h00, 8'h00);
      chk(f2(alertOe, faultAction), 16'h0000);
      $display("current test done");
      meas(0, 16'h0100);
      stat(16'h0000, 8'h00, 8'h00);
      meas(0, 16'h0900);
      chk(f2(1'b0, uvCrossed), 16'h0001);
      stat(16'h8001, 8'h40, 8'h00);
      meas(0, 16'h1100);
      stat(16'h8021, 8'hC0, 8'h00);
      chk(f2(alertOe, faultAction), 16'h0003);
      wr(`SLF_CMD_CLEAR, 16'h0000, 0);
      meas(0, 16'h0300);
      stat(16'h8001, 8'h20, 8'h00);
      chk(f2(alertOe, faultAction), 16'h0002);
      meas(0, 16'h0100);
      stat(16'h8001, 8'h30, 8'h00);
      wr(`SLF_CMD_CLEAR, 16'h0000, 0);
      supplyOff = 1'b1;
      meas(0, 16'h0100);
      chk(f2(1'b0, uvCrossed), 16'h0000);
      tonTimeout = 1'b1;
      @(negedge clk);
      tonTimeout = 1'b0;
      stat(16'h8001, 8'h04, 8'h00);
      wr(`SLF_CMD_CLEAR, 16'h0000, 0);
      $display("voltage test done");
      {supplyOff, alertEn, faultRespEn} = 3'h0;
      meas(2, 16'h0045);
      stat(16'h1004, 8'h00, 8'h01);
      meas(2, 16'h0055);
      stat(16'h1004, 8'h00, 8'h03);
      chk(f2(alertOe, faultAction), 16'h0000);
      faultRespEn = 1'b1;
      repeat (20) @(negedge clk);
      chk(f2(alertOe, faultAction), 16'h0001);
      wr(`SLF_CMD_CLEAR, 16'h0000, 0);
      $display("temperature test done");
      slf_host_model_inst.devAddr = 7'h21;
      wr(`SLF_CMD_OVF, 16'h0000, 2);
      chk(f2(1'b0, slf_host_model_inst.addrAck), 16'h0000);
      slf_host_model_inst.devAddr = `SLF_SLAVE_ADDR;
      rdc(`SLF_CMD_OVF, 2, 16'h1000);
      wr(8'h10, 16'h0000, 1);
      stat(16'h0002, 8'h00, 8'h00);
      $display("bus test done");
      testDone;
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      nErrors++;
      testDone;
   end
endmodule
